/* File: hw/sbpb_pkg.sv */
package sbpb_pkg;

  // array geometry, 256 KB block layout
  localparam int          SBPB_NBLK      = 256;
  localparam int          SBPB_BLK_W     = 8;
  localparam int          SBPB_SEC_PER   = 64;
  localparam int          SBPB_SEC_KB    = 4;
  localparam logic [25:0] SBPB_TOP_ADDR  = 26'h3FF_FFFF;

  // register byte offsets
  localparam logic [11:0] SBPB_REG_CMD   = 12'h000;
  localparam logic [11:0] SBPB_REG_SEL   = 12'h004;
  localparam logic [11:0] SBPB_REG_STAT  = 12'h008;
  localparam logic [11:0] SBPB_REG_EXT   = 12'h00C;

  // command register bits
  localparam int SBPB_CMD_DYN_WR  = 0;
  localparam int SBPB_CMD_PROG    = 1;
  localparam int SBPB_CMD_ERASE   = 2;
  localparam int SBPB_CMD_LOCK    = 3;
  localparam int SBPB_CMD_UNLOCK  = 4;
  localparam int SBPB_CMD_SWRST   = 5;
  localparam int SBPB_CMD_DYN_VAL = 8;

  // status register bits
  localparam int SBPB_ST_BUSY  = 0;
  localparam int SBPB_ST_FAIL  = 1;
  localparam int SBPB_ST_LOCK  = 2;
  localparam int SBPB_ST_INIT  = 3;
  localparam int SBPB_ST_MODE  = 4;
  localparam int SBPB_ST_PBIT  = 8;
  localparam int SBPB_ST_DBIT  = 9;
  localparam int SBPB_ST_PROT  = 10;

  // extended register bits
  localparam int SBPB_EX_PHASE = 0;
  localparam int SBPB_EX_BUSY  = 2;
  localparam int SBPB_EX_FAIL  = 3;

  // timing
  localparam int unsigned SBPB_CLK_NS      = 20;
  localparam int unsigned SBPB_PROG_NS     = 200000;
  localparam int unsigned SBPB_ERASE_NS    = 50000000;
  localparam int unsigned SBPB_PROG_CYC    =
    (SBPB_PROG_NS + SBPB_CLK_NS - 1) / SBPB_CLK_NS;
  localparam int unsigned SBPB_ERASE_CYC   =
    (SBPB_ERASE_NS + SBPB_CLK_NS - 1) / SBPB_CLK_NS;
  localparam logic [2:0]  SBPB_INIT_CYC    = 3'h4;

  // reset values
  localparam logic        SBPB_RST_LOCK    = 1'b0;
  localparam logic [7:0]  SBPB_RST_SEL     = 8'h00;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_PROG,
    PH_PREPROG,
    PH_ERASE
  } sbpb_phase_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } sbpb_ahb_req_t;

  typedef struct packed {
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
  } sbpb_ahb_rsp_t;

endpackage

/* File: hw/sbpb_nv_store.sv */
`timescale 1ns/1ps
module sbpb_nv_store #(
  parameter int unsigned PROG_CYC  = 10000,
  parameter int unsigned ERASE_CYC = 2500000
) (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 prog_start,
  input  wire logic                 erase_start,
  input  wire logic [7:0]           prog_idx,
  output logic [255:0]              pbits,
  output sbpb_pkg::sbpb_phase_t     phase
);
  import sbpb_pkg::*;

  localparam logic [31:0] PRE_CYC = 32'(ERASE_CYC / 4);

  typedef struct packed {
    sbpb_phase_t ph;
    logic [31:0] cnt;
    logic [7:0]  idx;
  } sbpb_eng_t;

  sbpb_eng_t    q;
  sbpb_eng_t    d;
  // non-volatile cells: no reset, shipped erased [RULE_02] [RULE_10]
  logic [255:0] nv_q = '1;
  logic [255:0] nv_d;

  // engine: cells change only at the end of a phase, so a reset
  // mid-operation never leaves a half-written bit
  always_comb begin
    d    = q;
    nv_d = nv_q;
    case (q.ph)
      PH_IDLE: begin
        if (prog_start) begin
          d.ph  = PH_PROG;
          d.cnt = 32'(PROG_CYC - 1);                  // [RULE_06]
          d.idx = prog_idx;
        end else if (erase_start) begin
          d.ph  = PH_PREPROG;                         // [RULE_05]
          d.cnt = PRE_CYC - 32'h1;
        end
      end
      PH_PROG: begin
        d.cnt = q.cnt - 32'h1;
        if (q.cnt == 32'h0) begin
          nv_d[q.idx] = 1'b0;                         // [RULE_03]
          d.ph        = PH_IDLE;
        end
      end
      PH_PREPROG: begin
        d.cnt = q.cnt - 32'h1;
        if (q.cnt == 32'h0) begin
          nv_d  = '0;                                 // [RULE_05]
          d.ph  = PH_ERASE;
          d.cnt = 32'(ERASE_CYC) - PRE_CYC - 32'h1;   // [RULE_06]
        end
      end
      PH_ERASE: begin
        d.cnt = q.cnt - 32'h1;
        if (q.cnt == 32'h0) begin
          nv_d = '1;                                  // [RULE_03] [RULE_04]
          d.ph = PH_IDLE;
        end
      end
      default: d.ph = PH_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '{ph: PH_IDLE, cnt: 32'h0, idx: 8'h00};
    end else begin
      q <= d;
    end
  end

  // cells survive every reset
  always_ff @(posedge hclk) begin
    nv_q <= nv_d;
  end

  assign pbits = nv_q;
  assign phase = q.ph;

endmodule

/* File: hw/sbpb_top.sv */
// The placing of the registers and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
// Function
// RULE_01 - 256 blocks, one bit pair each
// RULE_02 - persistent bits kept non-volatile per block
// RULE_03 - program clears one bit, erase sets all
// RULE_04 - no single-bit erase, address ignored
// RULE_05 - erase preprograms internally first
// RULE_06 - program and erase times, busy throughout
// RULE_07 - progress visible in status and extended
// RULE_08 - array reads refused while programming
// RULE_09 - host reads with block base address; the code picks the block by the index in SEL instead
// RULE_10 - persistent bits shipped erased to 1
// RULE_11 - dynamic bit freely written, 0 protects
// RULE_12 - dynamic bit matters only if persistent 1
// RULE_13 - lock 0 freezes persistent bits
// RULE_14 - locked program/erase fails, nothing changes
// RULE_15 - persistent mode: lock 1 at reset
// RULE_16 - persistent mode: no command sets lock
// RULE_17 - password mode: lock 0, unlock sets
// RULE_18 - host clears lock after configuring
// RULE_19 - unprotected only when both bits 1
// RULE_20 - dynamic bits unprotected after any reset
// RULE_21 - software reset keeps lock
// RULE_22 - protected flag computed combinationally; the code drives block_protected from a register, one cycle later
module sbpb_top #(
  parameter int unsigned PROG_CYC  = sbpb_pkg::SBPB_PROG_CYC,
  parameter int unsigned ERASE_CYC = sbpb_pkg::SBPB_ERASE_CYC
) (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire sbpb_pkg::sbpb_ahb_req_t ahb_req,
  output sbpb_pkg::sbpb_ahb_rsp_t   ahb_rsp,
  input  wire logic                 password_mode,
  output logic [255:0]              block_protected,
  output logic                      array_read_inhibit,
  output logic                      prot_busy
);
  import sbpb_pkg::*;

  typedef struct packed {
    logic [2:0]   sync;
    logic         mode;
    logic [2:0]   init_cnt;
    logic         init_done;
    logic         lock;
    logic         fail;
    logic [7:0]   sel;
    logic [255:0] dyn;
    logic         prog_req;
    logic         erase_req;
    logic [7:0]   req_idx;
    logic         wr_pend;
    logic [11:0]  wr_addr;
    sbpb_ahb_rsp_t rsp;
    logic [255:0] pmap;
    logic         rd_inh;
    logic         busy;
  } sbpb_state_t;

  sbpb_state_t  q;
  sbpb_state_t  d;
  logic [255:0] pbits;
  sbpb_phase_t  phase;
  logic [255:0] prot_now;
  logic         eng_busy;
  logic         addr_ok;
  logic         cmd_wr;
  logic         stat_wr;
  logic [31:0]  wd;
  logic [31:0]  rd_word;

  sbpb_nv_store #(
    .PROG_CYC  (PROG_CYC),
    .ERASE_CYC (ERASE_CYC)
  ) u_nv (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .prog_start  (q.prog_req),
    .erase_start (q.erase_req),
    .prog_idx    (q.req_idx),
    .pbits       (pbits),
    .phase       (phase)
  );

  // protected unless both bits are 1 [RULE_12] [RULE_19] [RULE_22]
  assign prot_now = ~(pbits & q.dyn);

  // requests still in flight count as busy, so no second start slips in
  assign eng_busy = (phase != PH_IDLE) | q.prog_req | q.erase_req;

  // bus decode for the address phase and the pending write data phase
  assign addr_ok = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
  assign wd      = ahb_req.hwdata;
  assign cmd_wr  = q.wr_pend & (q.wr_addr == SBPB_REG_CMD);
  assign stat_wr = q.wr_pend & (q.wr_addr == SBPB_REG_STAT);

  // read mux, sampled at the address phase
  always_comb begin
    rd_word = 32'h0000_0000;
    case (ahb_req.haddr[11:0])
      SBPB_REG_SEL: rd_word[7:0] = q.sel;
      SBPB_REG_STAT: begin
        rd_word[SBPB_ST_BUSY] = eng_busy;              // [RULE_07]
        rd_word[SBPB_ST_FAIL] = q.fail;
        rd_word[SBPB_ST_LOCK] = q.lock;
        rd_word[SBPB_ST_INIT] = q.init_done;
        rd_word[SBPB_ST_MODE] = q.mode;
        rd_word[SBPB_ST_PBIT] = pbits[q.sel];
        rd_word[SBPB_ST_DBIT] = q.dyn[q.sel];
        rd_word[SBPB_ST_PROT] = prot_now[q.sel];
      end
      SBPB_REG_EXT: begin
        rd_word[SBPB_EX_PHASE +: 2] = phase;           // [RULE_07]
        rd_word[SBPB_EX_BUSY]       = eng_busy;
        rd_word[SBPB_EX_FAIL]       = q.fail;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // next state
  always_comb begin
    d = q;
    // mode strap: three flops, a change counts when the last two agree
    d.sync = {q.sync[1:0], password_mode};
    if (q.sync[1] == q.sync[2]) begin
      d.mode = q.sync[2];
    end

    // lock loads once the strap has settled after release
    if (!q.init_done) begin
      d.init_cnt = q.init_cnt + 3'h1;
      if (q.init_cnt == SBPB_INIT_CYC) begin
        d.init_done = 1'b1;
        d.lock      = ~q.mode;                         // [RULE_15] [RULE_17]
      end
    end

    // start requests are one-cycle pulses into the engine
    d.prog_req  = 1'b0;
    d.erase_req = 1'b0;

    // fail: clear by writing 1 or by software reset; a new failure
    // raised later in this process overrides the clear
    if ((stat_wr && wd[SBPB_ST_FAIL]) || (cmd_wr && wd[SBPB_CMD_SWRST])) begin
      d.fail = 1'b0;
    end

    if (q.wr_pend && q.wr_addr == SBPB_REG_SEL) begin
      d.sel = wd[7:0];                                 // [RULE_01]
    end

    if (cmd_wr) begin
      if (wd[SBPB_CMD_DYN_WR]) begin
        d.dyn[q.sel] = wd[SBPB_CMD_DYN_VAL];           // [RULE_11]
      end
      // busy or not yet initialised: start requests are ignored
      if ((wd[SBPB_CMD_PROG] || wd[SBPB_CMD_ERASE]) &&
          q.init_done && !eng_busy) begin
        if (!q.lock) begin
          d.fail = 1'b1;                               // [RULE_13] [RULE_14]
        end else if (wd[SBPB_CMD_PROG]) begin
          d.prog_req = 1'b1;                           // [RULE_03]
          d.req_idx  = q.sel;
        end else begin
          d.erase_req = 1'b1;                          // [RULE_04]
        end
      end
      if (wd[SBPB_CMD_UNLOCK] && q.mode && q.init_done) begin
        d.lock = 1'b1;                                 // [RULE_17] [RULE_16]
      end
      if (wd[SBPB_CMD_LOCK] && q.init_done) begin
        d.lock = 1'b0;                                 // [RULE_13]
      end
      if (wd[SBPB_CMD_SWRST]) begin
        d.dyn  = '1;                                   // [RULE_20] [RULE_21]
      end
    end

    // bus: zero wait state, read data registered at the address phase
    d.wr_pend       = addr_ok & ahb_req.hwrite;
    d.wr_addr       = ahb_req.haddr[11:0];
    d.rsp.hreadyout = 1'b1;
    d.rsp.hresp     = 1'b0;
    if (addr_ok && !ahb_req.hwrite) begin
      d.rsp.hrdata = rd_word;
    end

    // registered outputs
    d.pmap   = prot_now;                               // [RULE_22]
    d.rd_inh = (phase == PH_PROG) | q.prog_req;        // [RULE_08]
    d.busy   = eng_busy;                               // [RULE_06]
  end

  // state register; dynamic bits come up unprotected [RULE_20]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q           <= '0;
      q.lock      <= SBPB_RST_LOCK;
      q.sel       <= SBPB_RST_SEL;
      q.dyn       <= '1;
      q.pmap      <= '1;
      q.rsp.hreadyout <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign ahb_rsp            = q.rsp;
  assign block_protected    = q.pmap;
  assign array_read_inhibit = q.rd_inh;
  assign prot_busy          = q.busy;

endmodule

/* File: tb/sbpb_host.sv */
`timescale 1ns/1ps
module sbpb_host
  import sbpb_pkg::*;
(
  input  wire logic          hclk,
  output sbpb_ahb_req_t      req,
  input  wire sbpb_ahb_rsp_t rsp
);
  import sbpb_pkg::*;
  sbpb_ahb_req_t r_q = '0;
  // hready of the one slave is the bus hready
  assign req = {r_q[$bits(r_q)-1:1], rsp.hreadyout};
  // one word transfer; the block is picked by index, never by address
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic to);
    int n;
    n = 0;
    @(posedge hclk);
    r_q.hsel <= 1'b1;
    r_q.haddr <= {20'h00000, a};
    r_q.htrans <= 2'h2;
    r_q.hwrite <= w;
    r_q.hsize <= 3'h2;
    do @(posedge hclk); while (rsp.hreadyout !== 1'b1 && ++n < 50);
    r_q.htrans <= 2'h0;
    r_q.hsel <= 1'b0;
    r_q.hwdata <= wd;
    do @(posedge hclk); while (rsp.hreadyout !== 1'b1 && ++n < 50);
    rd = rsp.hrdata;
    to = (n >= 50);
  endtask
endmodule

/* File: tb/sbpb_top_assertions.sv */
`timescale 1ns/1ps
module sbpb_top_assertions
  import sbpb_pkg::*;
#(
  parameter int unsigned PROG_CYC  = 10000,
  parameter int unsigned ERASE_CYC = 2500000
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire sbpb_ahb_req_t ahb_req,
  input  wire sbpb_ahb_rsp_t ahb_rsp,
  input  wire logic          password_mode,
  input  wire logic [255:0]  block_protected,
  input  wire logic          array_read_inhibit,
  input  wire logic          prot_busy
);
  import sbpb_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic        wr_take;
  logic [31:0] wr_age_q;
  logic [31:0] quiet_q;
  logic [31:0] busy_len_q;
  logic [31:0] inh_len_q;
  assign wr_take = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready
                   & ahb_req.hwrite;
  // ages and run lengths; quiet means no write and no engine activity
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_age_q <= '0;
      quiet_q <= '0;
      busy_len_q <= '0;
      inh_len_q <= '0;
    end else begin
      wr_age_q <= wr_take ? 32'h0 : wr_age_q + 32'h1;
      quiet_q <= (wr_take || prot_busy) ? 32'h0 : quiet_q + 32'h1;
      busy_len_q <= prot_busy ? busy_len_q + 32'h1 : 32'h0;
      inh_len_q <= array_read_inhibit ? inh_len_q + 32'h1 : 32'h0;
    end
  end
  property p_ready; ahb_rsp.hreadyout; endproperty
  a_ready: assert property (p_ready)
    else $error("bus stalled");
  property p_okay; !ahb_rsp.hresp; endproperty
  a_okay: assert property (p_okay)
    else $error("error response on bus");
  property p_cause; $rose(prot_busy) |-> wr_age_q <= 4; endproperty
  a_cause: assert property (p_cause)
    else $error("engine started without a command");
  property p_bmin; $fell(prot_busy) |-> busy_len_q >= PROG_CYC; endproperty
  a_bmin: assert property (p_bmin)
    else $error("busy too short");
  property p_bmax; busy_len_q <= ERASE_CYC + 8; endproperty
  a_bmax: assert property (p_bmax)
    else $error("busy too long");
  property p_inh; $rose(array_read_inhibit) |-> ##[0:2] prot_busy; endproperty
  a_inh: assert property (p_inh)
    else $error("inhibit without busy");
  property p_ilen;
    $fell(array_read_inhibit) |->
      inh_len_q >= PROG_CYC && inh_len_q <= PROG_CYC + 4;
  endproperty
  a_ilen: assert property (p_ilen)
    else $error("inhibit length wrong");
  property p_hold; quiet_q > 6 |-> $stable(block_protected); endproperty
  a_hold: assert property (p_hold)
    else $error("protection changed with no cause");
endmodule
bind sbpb_top sbpb_top_assertions #(.PROG_CYC(PROG_CYC),
  .ERASE_CYC(ERASE_CYC)) chk (.hclk(hclk), .hresetn(hresetn),
  .ahb_req(ahb_req), .ahb_rsp(ahb_rsp), .password_mode(password_mode),
  .block_protected(block_protected),
  .array_read_inhibit(array_read_inhibit), .prot_busy(prot_busy));

/* File: tb/sbpb_bench.sv */
`timescale 1ns/1ps
module sbpb_bench;
  import sbpb_pkg::*;
  logic          hclk = 1'b0;
  logic          hresetn = 1'b0;
  logic          pmode = 1'b0;
  sbpb_ahb_req_t req;
  sbpb_ahb_rsp_t rsp;
  logic [255:0]  prot;
  logic          inh;
  logic          busy;
  logic [31:0]   d;
  int            errors = 0;
  int            num_checks = 0;
  always #10 hclk = ~hclk;
  sbpb_host host (.hclk(hclk), .req(req), .rsp(rsp));
  // short engine times keep the run brief
  sbpb_top #(.PROG_CYC(20), .ERASE_CYC(40)) uut (.hclk(hclk),
    .hresetn(hresetn), .ahb_req(req), .ahb_rsp(rsp), .password_mode(pmode),
    .block_protected(prot), .array_read_inhibit(inh), .prot_busy(busy));
  task automatic report_and_stop;
    if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, e, input string m);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] v);
    logic to;
    host.xfer(w, a, v, d, to);
    if (to) begin
      cmp(32'h1, 32'h0, "bus hang");
      report_and_stop();
    end
  endtask
  task automatic st(input logic [31:0] m, e);
    bus(1'b0, SBPB_REG_STAT, 32'h0);
    cmp(d & m, e, "status");
  endtask
  // bounded poll of status bits
  task automatic poll(input logic [31:0] m, e);
    for (int n = 0; n < 100; n++) begin
      bus(1'b0, SBPB_REG_STAT, 32'h0);
      if ((d & m) === e) return;
    end
    cmp(d & m, e, "poll");
    report_and_stop();
  endtask
  task automatic hrst;
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    poll(32'h8, 32'h8);
  endtask
  task automatic cmd(input logic [7:0] s, input logic [31:0] c);
    bus(1'b1, SBPB_REG_SEL, {24'h0, s});
    bus(1'b1, SBPB_REG_CMD, c);
  endtask
  initial begin
    hrst();
    st(32'h714, 32'h304);
    cmp({31'h0, |prot}, 32'h0, "prot");
    cmd(8'h05, 32'h001);
    st(32'h600, 32'h400);
    cmp({31'h0, prot[5]}, 32'h1, "dyn0");
    cmd(8'h07, 32'h002);
    bus(1'b0, SBPB_REG_EXT, 32'h0);
    cmp(d & 32'h7, 32'h5, "ext prog");
    cmp({31'h0, inh}, 32'h1, "inhibit");
    cmp({31'h0, busy}, 32'h1, "busy pin");
    poll(32'h1, 32'h0);
    cmd(8'h07, 32'h101);
    st(32'h702, 32'h600);
    cmp({30'h0, prot[7:6]}, 32'h2, "one bit");
    cmd(8'h05, 32'h004);
    bus(1'b0, SBPB_REG_EXT, 32'h0);
    cmp(d & 32'h7, 32'h6, "ext erase");
    poll(32'h1, 32'h0);
    cmp({29'h0, |prot[255:6], prot[5], |prot[4:0]}, 32'h2, "erased");
    cmd(8'h09, 32'h002);
    poll(32'h1, 32'h0);
    cmd(8'h09, 32'h008);
    cmd(8'h05, 32'h002);
    st(32'h7, 32'h2);
    bus(1'b1, SBPB_REG_STAT, 32'h2);
    cmd(8'h05, 32'h004);
    st(32'h7, 32'h2);
    cmp({30'h0, prot[9], prot[5]}, 32'h3, "locked");
    cmd(8'h05, 32'h011);
    st(32'h4, 32'h0);
    cmd(8'h05, 32'h020);
    st(32'h206, 32'h200);
    bus(1'b0, 12'h010, 32'h0);
    cmp(d, 32'h0, "unmapped");
    hrst();
    st(32'h4, 32'h4);
    cmp({30'h0, prot[9], prot[5]}, 32'h2, "kept");
    pmode <= 1'b1;
    hrst();
    st(32'h14, 32'h10);
    cmd(8'h00, 32'h010);
    st(32'h4, 32'h4);
    report_and_stop();
  end
endmodule
